// File: design/eqpc_top.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - carrier detect low when signal and adapted
// - routing strap steers input to outputs
// - bypass strap picks equalized or raw
// - swing strap sets common amplitude, de-emphasis
// - register override beats strap value
// - float selects spi, hard low selects smbus
// - at most one serial interface enabled
// - spi answers only while select low
// - master clocks spi, device returns miso
// - two address straps give sixteen addresses
// - address straps latched once at power-up
// - smbus data only pulled low
// - each driver disabled independently
// - high interface strap forces power save
module eqpc_top
  import eqpc_pkg::*;
(
  // clock and asynchronous active-low reset
  input wire logic CLK,
  input wire logic RST_N,
  // four-level strap codes from the pad comparators
  input wire logic [1:0] ROUTE_STRAP,
  input wire logic [1:0] BYPASS_STRAP,
  input wire logic [1:0] SWING_DEEMPH_SELECT,
  input wire logic [1:0] IF_SEL_STRAP,
  input wire logic [1:0] SMBUS_ADDR_STRAP_LO,
  input wire logic [1:0] SMBUS_ADDR_STRAP_HI,
  // register overrides, on this clock
  input wire logic ROUTE_OVR_EN,
  input wire logic [1:0] ROUTE_OVR,
  input wire logic BYPASS_OVR_EN,
  input wire logic [1:0] BYPASS_OVR,
  input wire logic SWING_OVR_EN,
  input wire logic [1:0] SWING_OVR,
  // per-driver disables, on this clock
  input wire logic DRIVER_A_DIS,
  input wire logic DRIVER_B_DIS,
  // analog front-end status, asynchronous
  input wire logic SIGNAL_DETECT,
  input wire logic ADAPT_DONE,
  // spi select pin and return data, asynchronous
  input wire logic SS_N,
  input wire logic SPI_TX_BIT,
  // smbus engine asks for a low on the data line
  input wire logic SDA_PULL_REQ,
  // open-drain carrier flag
  output logic CARRIER_DETECT_N_O,
  output logic CARRIER_DETECT_N_OE,
  // selections handed to the datapath
  output logic [1:0] ROUTE_SEL,
  output logic [1:0] BYPASS_SEL,
  output logic [1:0] SWING_SEL,
  // driver enables
  output logic DRIVER_A_EN,
  output logic DRIVER_B_EN,
  // interface mode, at most one high
  output logic SPI_EN,
  output logic SMB_EN,
  output logic POWER_SAVE,
  // spi and smbus pin drives
  output logic SPI_SELECTED,
  output logic MISO_O,
  output logic MISO_OE,
  output logic SDA_O,
  output logic SDA_OE,
  // latched smbus address
  output logic [6:0] SMB_ADDR,
  output logic ADDR_VALID
);

  // all state of the block in one packed struct
  typedef struct packed {
    // pin synchronisers, two stages each
    logic [1:0] sd_s;
    logic [1:0] ad_s;
    logic [1:0] ss_s;
    logic [1:0] tx_s;
    // strap latch sequence
    eqpc_st_t st;
    logic [3:0] settle;
    logic [6:0] addr;
    logic addr_ok;
    // interface mode and its registered flags
    eqpc_if_t ifm;
    logic spi_en;
    logic smb_en;
    logic psave;
    // registered outputs
    logic cd_oe;
    logic [1:0] route;
    logic [1:0] bypass;
    logic [1:0] swing;
    logic en_a;
    logic en_b;
    logic spi_sel;
    logic miso_oe;
    logic miso_o;
    logic sda_oe;
  } eqpc_state_t;

  eqpc_state_t q, d;
  eqpc_lvl_t lv_route, lv_bypass, lv_swing, lv_if, lv_alo, lv_ahi;
  // synchronised pin values read by the next-state logic
  logic ss_n_sync, tx_sync, carrier_sync;

  // strap decode filter
  // routing strap: synchronised, then held before use
  eqpc_lvl_filter u_route (
    .clk(CLK),
    .rst_n(RST_N),
    .raw(ROUTE_STRAP),
    .level(lv_route)
  );

  // bypass strap
  eqpc_lvl_filter u_bypass (
    .clk(CLK),
    .rst_n(RST_N),
    .raw(BYPASS_STRAP),
    .level(lv_bypass)
  );

  // swing and de-emphasis strap
  eqpc_lvl_filter u_swing (
    .clk(CLK),
    .rst_n(RST_N),
    .raw(SWING_DEEMPH_SELECT),
    .level(lv_swing)
  );

  // interface select strap
  eqpc_lvl_filter u_ifsel (
    .clk(CLK),
    .rst_n(RST_N),
    .raw(IF_SEL_STRAP),
    .level(lv_if)
  );

  // low address strap
  eqpc_lvl_filter u_alo (
    .clk(CLK),
    .rst_n(RST_N),
    .raw(SMBUS_ADDR_STRAP_LO),
    .level(lv_alo)
  );

  // high address strap
  eqpc_lvl_filter u_ahi (
    .clk(CLK),
    .rst_n(RST_N),
    .raw(SMBUS_ADDR_STRAP_HI),
    .level(lv_ahi)
  );

  // second stages of the pin synchronisers
  assign ss_n_sync = q.ss_s[1];
  assign tx_sync = q.tx_s[1];
  // carrier needs both front-end flags after their own syncs
  assign carrier_sync = q.sd_s[1] & q.ad_s[1];

  // next-state logic
  always_comb begin
    d = q;

    // asynchronous pins pass two flops before any logic
    d.ss_s = {q.ss_s[0], SS_N};
    d.tx_s = {q.tx_s[0], SPI_TX_BIT};
    d.sd_s = {q.sd_s[0], SIGNAL_DETECT};
    d.ad_s = {q.ad_s[0], ADAPT_DONE};

    d.cd_oe = carrier_sync;

    case (lv_if)
      EQPC_LVL_F: d.ifm = EQPC_IF_SPI;
      // hard pull-down gives smbus
      EQPC_LVL_L: d.ifm = EQPC_IF_SMB;
      EQPC_LVL_H: d.ifm = EQPC_IF_SAVE;
      // resistive low leaves both ports off
      default: d.ifm = EQPC_IF_NONE;
    endcase

    // mode flags get flops of their own so outputs stay clean
    d.spi_en = (d.ifm == EQPC_IF_SPI);
    d.smb_en = (d.ifm == EQPC_IF_SMB);
    d.psave = (d.ifm == EQPC_IF_SAVE);

    if (ROUTE_OVR_EN) begin
      d.route = ROUTE_OVR;
    end else begin
      d.route = 2'(lv_route);
    end
    if (BYPASS_OVR_EN) begin
      d.bypass = BYPASS_OVR;
    end else begin
      d.bypass = 2'(lv_bypass);
    end
    if (SWING_OVR_EN) begin
      d.swing = SWING_OVR;
    end else begin
      d.swing = 2'(lv_swing);
    end

    // independent disables
    // power save turns both drivers off as well
    d.en_a = !DRIVER_A_DIS && !q.psave;
    d.en_b = !DRIVER_B_DIS && !q.psave;

    d.spi_sel = q.spi_en && !ss_n_sync;
    d.miso_oe = d.spi_sel;
    // data is held low whenever the port is not selected
    d.miso_o = d.spi_sel && tx_sync;

    // open drain data, low only
    // requests are ignored unless the smbus port is chosen
    d.sda_oe = q.smb_en && SDA_PULL_REQ;

    case (q.st)
      // let the strap filters settle after reset
      EQPC_ST_WAIT: begin
        if (q.settle == EQPC_SETTLE_CNT) begin
          d.st = EQPC_ST_LATCH;
        end else begin
          d.settle = q.settle + 4'h1;
        end
      end
      // single capture of the address straps
      EQPC_ST_LATCH: begin
        d.addr = EQPC_SMB_BASE | {3'h0, 2'(lv_ahi), 2'(lv_alo)};
        d.addr_ok = 1'h1;
        d.st = EQPC_ST_RUN;
      end
      // later strap changes are never looked at again
      EQPC_ST_RUN: d.st = EQPC_ST_RUN;
      default: d.st = EQPC_ST_WAIT;
    endcase
  end

  // state register; reset clears outputs, select idles high
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '{
        sd_s: 2'h0,
        ad_s: 2'h0,
        ss_s: 2'h3,
        tx_s: 2'h0,
        st: EQPC_ST_WAIT,
        settle: 4'h0,
        addr: 7'h00,
        addr_ok: 1'h0,
        ifm: EQPC_IF_NONE,
        spi_en: 1'h0,
        smb_en: 1'h0,
        psave: 1'h0,
        cd_oe: 1'h0,
        route: 2'h0,
        bypass: 2'h0,
        swing: 2'h0,
        en_a: 1'h0,
        en_b: 1'h0,
        spi_sel: 1'h0,
        miso_oe: 1'h0,
        miso_o: 1'h0,
        sda_oe: 1'h0
      };
    end else begin
      q <= d;
    end
  end

  // open-drain pins only ever drive low; the enable does the work
  assign CARRIER_DETECT_N_O = 1'b0;
  assign CARRIER_DETECT_N_OE = q.cd_oe;

  // datapath selections
  assign ROUTE_SEL = q.route;
  assign BYPASS_SEL = q.bypass;
  assign SWING_SEL = q.swing;

  // driver enables
  assign DRIVER_A_EN = q.en_a;
  assign DRIVER_B_EN = q.en_b;

  // interface mode flags, each from its own flop
  assign SPI_EN = q.spi_en;
  assign SMB_EN = q.smb_en;
  assign POWER_SAVE = q.psave;

  // serial port pins
  assign SPI_SELECTED = q.spi_sel;
  assign MISO_O = q.miso_o;
  assign MISO_OE = q.miso_oe;
  assign SDA_O = 1'b0;
  assign SDA_OE = q.sda_oe;

  // latched address
  assign SMB_ADDR = q.addr;
  assign ADDR_VALID = q.addr_ok;
endmodule
`default_nettype wire

// File: design/eqpc_pkg.sv
package eqpc_pkg;
  // 4-level strap codes after decoding
  typedef enum logic [1:0] {
    EQPC_LVL_L = 2'h0,
    EQPC_LVL_R = 2'h1,
    EQPC_LVL_F = 2'h2,
    EQPC_LVL_H = 2'h3
  } eqpc_lvl_t;

  // serial control interface in use
  typedef enum logic [1:0] {
    EQPC_IF_NONE = 2'h0,
    EQPC_IF_SPI = 2'h1,
    EQPC_IF_SMB = 2'h3,
    EQPC_IF_SAVE = 2'h2
  } eqpc_if_t;

  // strap latch sequence, gray along the path
  typedef enum logic [1:0] {
    EQPC_ST_WAIT = 2'h0,
    EQPC_ST_LATCH = 2'h1,
    EQPC_ST_RUN = 2'h3
  } eqpc_st_t;

  // base of the 7-bit smbus address; low four bits come from the straps
  localparam logic [6:0] EQPC_SMB_BASE = 7'h10;
  localparam int EQPC_ADDR_W = 7;
  // cycles a decoded level must hold before it is accepted
  localparam logic [3:0] EQPC_STABLE_CNT = 4'h8;
  // cycles after reset release before straps are latched
  localparam logic [3:0] EQPC_SETTLE_CNT = 4'hF;
endpackage

// File: design/eqpc_lvl_filter.sv
`timescale 1ns/100ps
`default_nettype none
module eqpc_lvl_filter
  import eqpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] raw,
  output var eqpc_lvl_t level
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] cand;
    logic [3:0] cnt;
    eqpc_lvl_t lvl;
  } eqpc_flt_t;

  eqpc_flt_t q, d;

  // accept a level only after it holds for a run of cycles
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    if (q.s2 != q.cand) begin
      d.cand = q.s2;
      d.cnt = 4'h0;
    end else if (q.cnt < EQPC_STABLE_CNT) begin
      d.cnt = q.cnt + 4'h1;
    end else begin
      d.lvl = eqpc_lvl_t'(q.cand);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{s1: EQPC_LVL_F, s2: EQPC_LVL_F, cand: EQPC_LVL_F,
             cnt: 4'h0, lvl: EQPC_LVL_F};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule
`default_nettype wire

// File: bench/eqpc_properties.sv
`timescale 1ns/100ps
`default_nettype none
module eqpc_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ROUTE_OVR_EN,
  input wire logic [1:0] ROUTE_OVR,
  input wire logic DRIVER_A_DIS,
  input wire logic DRIVER_B_DIS,
  input wire logic SIGNAL_DETECT,
  input wire logic ADAPT_DONE,
  input wire logic CARRIER_DETECT_N_OE,
  input wire logic [1:0] ROUTE_SEL,
  input wire logic DRIVER_A_EN,
  input wire logic DRIVER_B_EN,
  input wire logic SPI_EN,
  input wire logic SMB_EN,
  input wire logic POWER_SAVE,
  input wire logic MISO_O,
  input wire logic MISO_OE,
  input wire logic SDA_OE,
  input wire logic [6:0] SMB_ADDR,
  input wire logic ADDR_VALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  one_if_a: assert property ($onehot0({SPI_EN, SMB_EN, POWER_SAVE}))
    else $error("two interfaces on");
  cd_lat_a: assert property (CARRIER_DETECT_N_OE ==
    $past(SIGNAL_DETECT && ADAPT_DONE, 3)) else $error("carrier flag");
  drv_a_a: assert property (DRIVER_A_DIS |=> !DRIVER_A_EN)
    else $error("driver a on");
  drv_b_a: assert property (DRIVER_B_DIS |=> !DRIVER_B_EN)
    else $error("driver b on");
  save_off_a: assert property (POWER_SAVE |=> !DRIVER_A_EN && !DRIVER_B_EN)
    else $error("drivers on in save");
  sda_mode_a: assert property (SDA_OE |-> SMB_EN || $past(SMB_EN))
    else $error("sda pulled outside smbus");
  miso_mode_a: assert property (MISO_OE |-> SPI_EN || $past(SPI_EN))
    else $error("miso driven outside spi");
  route_ovr_a: assert property (ROUTE_OVR_EN |=> ROUTE_SEL == $past(ROUTE_OVR))
    else $error("override ignored");
  addr_hold_a: assert property (ADDR_VALID |=> ADDR_VALID &&
    $stable(SMB_ADDR) && SMB_ADDR[6:4] == 3'h1) else $error("address moved");
  cover property (SMB_EN && SDA_OE);
  cover property (SPI_EN && MISO_OE);
  miso_data_a: assert property (MISO_O |-> MISO_OE)
    else $error("miso data while idle");
  cover property (POWER_SAVE);
  cover property (CARRIER_DETECT_N_OE && ADDR_VALID);
endmodule
bind eqpc_top eqpc_chk eqpc_chk_i (.*);
`default_nettype wire

// File: bench/eqpc_master.sv
`timescale 1ns/100ps
`default_nettype none
module eqpc_master (
  input wire logic sel,
  input wire logic sda_oe,
  output logic ss_n,
  output logic sda
);
  assign ss_n = !sel;
  assign sda = !sda_oe;
endmodule
`default_nettype wire

// File: bench/eqpc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module eqpc_top_tb;
  logic clk, rst_n, go, roe, boe, soe, da, db, sd, ad, sel, tx, pull;
  logic [1:0] r, b, s, ro, bo, so, ifs, alo, ahi, rs, bs, ss;
  logic cd, mo, so_e, sda, ss_n, ae, be, spi, smb, ps, av;
  logic cdo, sdao, spsel, miso;
  logic [6:0] addr;
  logic [26:0] obs, e;
  logic [26:0] q[$];
  int n_tests, fail_count, seed = 32'h3FF3;
  eqpc_top eqpc_top_i (.CLK(clk), .RST_N(rst_n), .ROUTE_STRAP(r),
    .BYPASS_STRAP(b), .SWING_DEEMPH_SELECT(s), .IF_SEL_STRAP(ifs),
    .SMBUS_ADDR_STRAP_LO(alo), .SMBUS_ADDR_STRAP_HI(ahi),
    .ROUTE_OVR_EN(roe), .ROUTE_OVR(ro), .BYPASS_OVR_EN(boe),
    .BYPASS_OVR(bo), .SWING_OVR_EN(soe), .SWING_OVR(so),
    .DRIVER_A_DIS(da), .DRIVER_B_DIS(db), .SIGNAL_DETECT(sd),
    .ADAPT_DONE(ad), .SS_N(ss_n), .SPI_TX_BIT(tx), .SDA_PULL_REQ(pull),
    .CARRIER_DETECT_N_O(cdo), .CARRIER_DETECT_N_OE(cd), .ROUTE_SEL(rs),
    .BYPASS_SEL(bs), .SWING_SEL(ss), .DRIVER_A_EN(ae), .DRIVER_B_EN(be),
    .SPI_EN(spi), .SMB_EN(smb), .POWER_SAVE(ps), .SPI_SELECTED(spsel),
    .MISO_O(miso), .MISO_OE(mo), .SDA_O(sdao), .SDA_OE(so_e),
    .SMB_ADDR(addr), .ADDR_VALID(av));
  eqpc_master eqpc_master_i (.sel(sel), .sda_oe(so_e), .ss_n(ss_n),
    .sda(sda));
  assign obs = {rs, bs, ss, ae, be, spi, smb, ps, cd, cdo, mo, miso, spsel,
    so_e, sdao, sda, addr, av};
  // expected outputs from the present inputs
  function automatic logic [26:0] exp_f();
    logic p, m, l;
    p = (ifs == 2'h3);
    m = (ifs == 2'h2);
    l = (ifs == 2'h0);
    // address from the power-up straps: hi code 3, lo code 1
    return {roe ? ro : r, boe ? bo : b, soe ? so : s, !da && !p,
      !db && !p, m, l, p, sd & ad, 1'b0, m & sel, m & sel & tx, m & sel,
      l & pull, 1'b0, !(l & pull), eqpc_pkg::EQPC_SMB_BASE | 7'h0D, 1'b1};
  endfunction
  task automatic tally_and_finish();
    $display("tests %0d fails %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // random settings, then note the expected result
  task automatic run(input int n);
    logic [31:0] v;
    for (int k = 0; k < n; k++) begin
      v = $random(seed);
      @(posedge clk);
      {ro, bo, so, ifs, r, b, s, alo, ahi} <= v[17:0];
      {roe, boe, soe, da, db, sd, ad, sel, tx, pull} <= v[27:18];
      repeat (20) @(posedge clk);
      q.push_back(exp_f());
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      $display("test %0d done", k);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {r, b, s, ro, bo, so, roe, boe, soe, da, db, sd, ad} = '0;
    {sel, tx, pull, go, rst_n} = '0;
    ifs = 2'h2;
    alo = 2'h1;
    ahi = 2'h3;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (25) @(posedge clk);
    run(60);
    tally_and_finish();
  end
  // watchdog against a hang
  initial begin
    #30000;
    fail_count++;
    tally_and_finish();
  end
  always @(posedge clk) begin
    if (go === 1'b1) begin
      e = q.pop_front();
      n_tests++;
      if (obs !== e) begin
        fail_count++;
        $display("[FAIL] %0t outputs %h expected %h", $time, obs, e);
      end
    end
  end
endmodule
`default_nettype wire
